// ---- core/dbam_mapper.sv ----
// Direct bank address mapper: translates core operand addresses to physical ones.
// Assumes the core issues one request per cycle on sys_clk and holds no handshake.
// Operation
// RULE1: Direct operands 0x0000 to 0x007F go to the same physical address for any bank.
// RULE2: The bank selector is three bits, resets to zero, and zero maps 0x0090-0x00FF to itself.
// RULE3: Selector values one to seven send 0x0080-0x00FF to 128-byte windows from 0x0100 to 0x047F.
// RULE4: The register area 0x0100-0x01FF is RAM and ordinary accesses read and write it.
// RULE5: The top 0xFFC0-0xFFFF of program memory is the vector table of start addresses.
// RULE6: Program addresses 0xFFBB-0xFFBF are kept for the non-volatile setting data.
// RULE7: Bank windows stop at the variant's RAM end, 0x018F or 0x028F on the smaller parts.
// RULE8: Only direct operands are translated; other modes pass the full address unchanged.
`timescale 1ns/1ns
`default_nettype none
module dbam_mapper #(
  parameter dbam_pkg::dbam_variant_t VARIANT = dbam_pkg::DBAM_VAR_FULL
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // Bank selector update from the core
  input wire logic selWrite,
  input wire logic [2:0] selData,
  // Request from the core
  input wire dbam_pkg::dbam_req_t req,
  // Answer toward the memory array
  output dbam_pkg::dbam_resp_t resp,
  output logic [2:0] directBankSelect
);

  // ----------------------------------------------------------------
  // Variant limit
  // ----------------------------------------------------------------
  logic [15:0] ramLast;

  always_comb
  begin
    case (VARIANT)
      dbam_pkg::DBAM_VAR_SMALL: ramLast = dbam_pkg::DBAM_RAM_LAST_SMALL;
      dbam_pkg::DBAM_VAR_MID: ramLast = dbam_pkg::DBAM_RAM_LAST_MID;
      default: ramLast = dbam_pkg::DBAM_RAM_LAST_FULL;
    endcase
  end

  // ----------------------------------------------------------------
  // Bank selector
  // ----------------------------------------------------------------
  logic [2:0] sel_q;
  logic [2:0] sel_d;

  always_comb
  begin
    sel_d = sel_q;
    if (selWrite)
    begin
      sel_d = selData;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      sel_q <= dbam_pkg::DBAM_SEL_RESET; // [RULE2]
    end
    else
    begin
      sel_q <= sel_d;
    end
  end

  // ----------------------------------------------------------------
  // Translation
  // ----------------------------------------------------------------
  // The selector in force is the registered one, so a selector write and a
  // request in the same cycle use the old bank; this matches an instruction
  // boundary in the core and keeps the path short.
  logic [15:0] physAddr;
  logic inWindow;
  dbam_pkg::dbam_area_t area;

  always_comb
  begin
    physAddr = req.addr; // [RULE8]
    inWindow = 1'b0;
    if (req.direct)
    begin
      if (req.addr[7:0] <= dbam_pkg::DBAM_IO_LAST[7:0])
      begin
        physAddr = {8'h00, req.addr[7:0]}; // [RULE1]
      end
      else if (sel_q == dbam_pkg::DBAM_SEL_RESET)
      begin
        physAddr = {8'h00, req.addr[7:0]}; // [RULE2]
      end
      else
      begin
        // Window base is (selector + 1) * 128: selector one lands on 0x0100.
        physAddr = {5'h00, 4'({1'b0, sel_q} + 4'h1), req.addr[6:0]}; // [RULE3]
        inWindow = 1'b1;
      end
    end
  end

  dbam_area_decode u_decode (
    .physAddr(physAddr),
    .ramLast(ramLast),
    .area(area)
  );

  // ----------------------------------------------------------------
  // Answer register
  // ----------------------------------------------------------------
  // A window past the implemented RAM is refused rather than aliased, and
  // program-memory tables are read-only from the data path.
  dbam_pkg::dbam_resp_t resp_q;
  dbam_pkg::dbam_resp_t resp_d;
  logic refuse;

  always_comb
  begin
    refuse = (inWindow && !area.ram) || // [RULE7]
             (req.write && (area.nonvolatile_setting_store || area.vec)); // [RULE5] [RULE6]
    resp_d.valid = req.valid && !refuse;
    resp_d.fault = req.valid && refuse;
    resp_d.write = req.valid && req.write;
    resp_d.addr = req.valid ? physAddr : 16'h0000;
    resp_d.area = req.valid ? area : '0;
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      resp_q <= '0;
    end
    else
    begin
      resp_q <= resp_d;
    end
  end

  assign resp = resp_q;
  assign directBankSelect = sel_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  chk_io_passthru: assert property ( // [RULE1]
    req.valid && req.direct && (req.addr[7:0] <= 8'h7f)
    |=> resp.valid && (resp.addr == {8'h00, $past(req.addr[7:0])}))
    else $error("Direct I/O operand was remapped.");

  chk_sel_reset: assert property ( // [RULE2]
    $past(srst) |-> (directBankSelect == 3'h0))
    else $error("Bank selector not zero after reset.");

  chk_bank0_ident: assert property ( // [RULE2]
    req.valid && req.direct && (directBankSelect == 3'h0) && (req.addr[7:0] >= 8'h90)
    |=> resp.valid && (resp.addr == {8'h00, $past(req.addr[7:0])}))
    else $error("Bank zero operand not mapped to itself.");

  chk_window_base: assert property ( // [RULE3]
    req.valid && req.direct && (directBankSelect != 3'h0) && req.addr[7]
    && !req.write && (VARIANT == dbam_pkg::DBAM_VAR_FULL)
    |=> resp.valid && (resp.addr >= 16'h0100) && (resp.addr <= 16'h047f)
    && (resp.addr[6:0] == $past(req.addr[6:0]))
    && (resp.addr[10:7] == 4'($past(directBankSelect)) + 4'h1))
    else $error("Bank window address wrong.");

  chk_gpr_is_ram: assert property ( // [RULE4]
    resp.valid && resp.area.gpr |-> resp.area.ram && (resp.addr >= 16'h0100)
    && (resp.addr <= 16'h01ff))
    else $error("Register area not seen as RAM.");

  chk_vec_area: assert property ( // [RULE5]
    req.valid && !req.direct && (req.addr >= 16'hffc0)
    |=> resp.area.vec && (resp.valid != resp.write))
    else $error("Vector table not decoded or not protected.");

  chk_nvr_area: assert property ( // [RULE6]
    req.valid && !req.direct && (req.addr >= 16'hffbb) && (req.addr <= 16'hffbf)
    |=> resp.area.nonvolatile_setting_store && !resp.area.vec)
    else $error("Setting data area not decoded.");

  // Only direct operands are limited; other modes reach the full map unchecked.
  chk_ram_limit: assert property ( // [RULE7]
    resp.valid && $past(req.direct) && (resp.addr >= 16'h0100) && (resp.addr <= 16'h047f)
    |-> (resp.addr <= ramLast))
    else $error("Access beyond implemented RAM.");

  chk_other_modes: assert property ( // [RULE8]
    req.valid && !req.direct ##1 resp.valid |-> resp.addr == $past(req.addr))
    else $error("Non-direct address altered.");

  cov_window: cover property (req.valid && req.direct && directBankSelect == 3'h7 ##1 resp.valid);
  cov_refused: cover property (resp.fault);
  cov_sel_change: cover property (selWrite ##1 req.valid && req.direct ##1 resp.valid);

endmodule
`default_nettype wire

// ---- include/dbam_pkg.sv ----
// Constants and carrier types of the direct bank address mapper.
// Assumes a 16-bit core address space and a single core clock.
package dbam_pkg;

  // ----------------------------------------------------------------
  // Address map
  // ----------------------------------------------------------------
  localparam logic [15:0] DBAM_IO_LAST = 16'h007f;
  localparam logic [15:0] DBAM_RAM_FIRST = 16'h0080;
  localparam logic [15:0] DBAM_GPR_FIRST = 16'h0100;
  localparam logic [15:0] DBAM_GPR_LAST = 16'h01ff;
  localparam logic [15:0] DBAM_NVR_FIRST = 16'hffbb;
  localparam logic [15:0] DBAM_NVR_LAST = 16'hffbf;
  localparam logic [15:0] DBAM_VEC_FIRST = 16'hffc0;
  localparam logic [15:0] DBAM_VEC_LAST = 16'hffff;

  // Last implemented RAM byte for each size variant.
  localparam logic [15:0] DBAM_RAM_LAST_SMALL = 16'h018f;
  localparam logic [15:0] DBAM_RAM_LAST_MID = 16'h028f;
  localparam logic [15:0] DBAM_RAM_LAST_FULL = 16'h047f;

  // ----------------------------------------------------------------
  // Bank selector fields
  // ----------------------------------------------------------------
  localparam logic [2:0] DBAM_SEL_RESET = 3'h0;
  localparam int DBAM_WIN_BITS = 7;

  typedef enum logic [1:0] {
    DBAM_VAR_SMALL,
    DBAM_VAR_MID,
    DBAM_VAR_FULL
  } dbam_variant_t;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic valid;
    logic direct;
    logic write;
    logic [15:0] addr;
  } dbam_req_t;

  typedef struct packed {
    logic io;
    logic ram;
    logic gpr;
    logic nonvolatile_setting_store;
    logic vec;
  } dbam_area_t;

  typedef struct packed {
    logic valid;
    logic fault;
    logic write;
    logic [15:0] addr;
    dbam_area_t area;
  } dbam_resp_t;

endpackage

// ---- core/dbam_area_decode.sv ----
// Combinational decoder of the special areas for one physical address.
// Assumes the caller supplies the last implemented RAM byte of the variant.
`timescale 1ns/1ns
`default_nettype none
module dbam_area_decode (
  // Address in
  input wire logic [15:0] physAddr,
  input wire logic [15:0] ramLast,
  // Area flags out
  output dbam_pkg::dbam_area_t area
);

  always_comb
  begin
    area.io = (physAddr <= dbam_pkg::DBAM_IO_LAST);
    area.ram = (physAddr >= dbam_pkg::DBAM_RAM_FIRST) && (physAddr <= ramLast);
    // The register area is ordinary RAM as well, so both flags rise together.
    area.gpr = (physAddr >= dbam_pkg::DBAM_GPR_FIRST) &&
               (physAddr <= dbam_pkg::DBAM_GPR_LAST) && (physAddr <= ramLast); // [RULE4]
    area.nonvolatile_setting_store = (physAddr >= dbam_pkg::DBAM_NVR_FIRST) &&
               (physAddr <= dbam_pkg::DBAM_NVR_LAST); // [RULE6]
    area.vec = (physAddr >= dbam_pkg::DBAM_VEC_FIRST); // [RULE5]
  end

endmodule
`default_nettype wire

// ---- tb/dbam_core_model.sv ----
// Core-side model: issues direct and other requests and loads the bank selector.
// Assumes the mapper takes a request at one edge and answers at the next.
`timescale 1ns/1ns
`default_nettype none
module dbam_core_model (
  // Clock
  input wire logic sys_clk,
  // Drive toward the mapper
  output var dbam_pkg::dbam_req_t req,
  output logic selWrite,
  output logic [2:0] selData
);
  initial
  begin
    req = '0;
    selWrite = 1'b0;
    selData = 3'h0;
  end

  // Selector data means nothing without the pulse, so it is scrambled afterwards.
  task automatic set_sel(input logic [2:0] v);
    @(posedge sys_clk);
    selWrite <= 1'b1;
    selData <= v;
    @(posedge sys_clk);
    selWrite <= 1'b0;
    selData <= ~v;
  endtask

  // Returns one time step after the edge that registers the answer.
  task automatic access(input logic d, input logic w, input logic [15:0] a);
    @(posedge sys_clk);
    req <= '{valid: 1'b1, direct: d, write: w, addr: a};
    @(posedge sys_clk);
    req <= '{valid: 1'b0, direct: ~d, write: ~w, addr: ~a};
    #1;
  endtask
endmodule
`default_nettype wire

// ---- tb/dbam_mapper_tb.sv ----
// Self-checking bench of the direct bank address mapper, full, mid and small RAM variants.
// Assumes the core model drives all three instances with the same requests.
`timescale 1ns/1ns
`default_nettype none
module dbam_mapper_tb;
  logic sys_clk;
  logic srst;
  dbam_pkg::dbam_req_t req;
  logic selWrite;
  logic [2:0] selData;
  dbam_pkg::dbam_resp_t resp;
  dbam_pkg::dbam_resp_t respSmall;
  dbam_pkg::dbam_resp_t respMid;
  logic [2:0] directBankSelect;
  int nFail = 0;
  int cmpCount = 0;

  dbam_core_model dbam_core_model_inst (.sys_clk(sys_clk), .req(req), .selWrite(selWrite),
    .selData(selData));
  dbam_mapper dbam_mapper_inst (.sys_clk(sys_clk), .srst(srst), .selWrite(selWrite),
    .selData(selData), .req(req), .resp(resp), .directBankSelect(directBankSelect));
  dbam_mapper #(.VARIANT(dbam_pkg::DBAM_VAR_SMALL)) dbam_mapper_inst_small (.sys_clk(sys_clk),
    .srst(srst), .selWrite(selWrite), .selData(selData), .req(req), .resp(respSmall),
    .directBankSelect());
  dbam_mapper #(.VARIANT(dbam_pkg::DBAM_VAR_MID)) dbam_mapper_inst_mid (.sys_clk(sys_clk),
    .srst(srst), .selWrite(selWrite), .selData(selData), .req(req), .resp(respMid),
    .directBankSelect());

  // ----------------------------------------------------------------
  // Compare helpers
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    cmpCount++;
    if (got !== exp)
    begin
      nFail++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Area flags are given as {io, ram, gpr, nvr, vec}.
  task automatic go(input logic d, input logic w, input logic [15:0] a,
    input logic [15:0] exp, input logic [4:0] ar);
    dbam_core_model_inst.access(d, w, a);
    chk("valid", 16'h0001, {15'h0, resp.valid});
    chk("addr", exp, resp.addr);
    chk("area", {11'h0, ar}, {11'h0, resp.area});
    chk("write", {15'h0, w}, {15'h0, resp.write});
    chk("fault", 16'h0000, {15'h0, resp.fault});
  endtask

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", cmpCount, nFail);
    if (nFail == 0 && cmpCount > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_low();
    chk("selector reset", 16'h0000, {13'h0, directBankSelect});
    go(1'b1, 1'b0, 16'h0090, 16'h0090, 5'h08);
    go(1'b1, 1'b1, 16'h00ff, 16'h00ff, 5'h08);
    dbam_core_model_inst.set_sel(3'h5);
    go(1'b1, 1'b0, 16'h007f, 16'h007f, 5'h10);
    go(1'b1, 1'b1, 16'h0000, 16'h0000, 5'h10);
  endtask

  // Every nonzero selector, first and last byte of each window.
  task automatic t_windows();
    logic [4:0] ar;
    for (int s = 1; s < 8; s++)
    begin
      dbam_core_model_inst.set_sel(s[2:0]);
      ar = (s < 3) ? 5'h0c : 5'h08;
      go(1'b1, 1'b1, 16'h0080, {5'h0, 4'(s + 1), 7'h00}, ar);
      chk("selector", {13'h0, s[2:0]}, {13'h0, directBankSelect});
      go(1'b1, 1'b0, 16'h00ff, {5'h0, 4'(s + 1), 7'h7f}, ar);
    end
  endtask

  // The small part ends at 0x018f, so window 2 is cut after its first 16 bytes.
  task automatic t_limit();
    dbam_core_model_inst.set_sel(3'h2);
    go(1'b1, 1'b0, 16'h008f, 16'h018f, 5'h0c);
    chk("small ok", 16'h0001, {15'h0, respSmall.valid});
    go(1'b1, 1'b0, 16'h0090, 16'h0190, 5'h0c);
    chk("small fault", 16'h0001, {15'h0, respSmall.fault});
    dbam_core_model_inst.set_sel(3'h4);
    go(1'b1, 1'b0, 16'h008f, 16'h028f, 5'h08);
    chk("mid ok", 16'h0001, {15'h0, respMid.valid});
    go(1'b1, 1'b0, 16'h0090, 16'h0290, 5'h08);
    chk("mid fault", 16'h0001, {15'h0, respMid.fault});
  endtask

  task automatic t_other();
    go(1'b0, 1'b0, 16'h0085, 16'h0085, 5'h08);
    go(1'b0, 1'b1, 16'h1234, 16'h1234, 5'h00);
    go(1'b0, 1'b0, 16'hffc2, 16'hffc2, 5'h01);
    go(1'b0, 1'b0, 16'hffbb, 16'hffbb, 5'h02);
    go(1'b0, 1'b0, 16'hffbf, 16'hffbf, 5'h02);
    dbam_core_model_inst.access(1'b0, 1'b1, 16'hffc0);
    chk("vector write refused", 16'h0001, {15'h0, resp.fault});
  endtask

  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  initial
  begin
    #200000;
    nFail++;
    end_of_test();
  end

  initial
  begin
    srst = 1'b1;
    repeat (6) @(posedge sys_clk);
    srst <= 1'b0;
    @(posedge sys_clk);
    #1;
    t_low();
    t_windows();
    t_limit();
    t_other();
    end_of_test();
  end
endmodule
`default_nettype wire
